// ==== hdl/tcrp_consts.vh ====
`ifndef TCRP_CONSTS_VH
`define TCRP_CONSTS_VH

// Clock rate and specified times; cycle counts are derived from these in the top module.
`define TCRP_CLK_MHZ        200
`define TCRP_PASS_NOLFD_US  200000
`define TCRP_PASS_LFD_US    350000
`define TCRP_XFER_US        6500
`define TCRP_STEP_EXT_US    160000
`define TCRP_STEP_INT_US    240000
`define TCRP_NUM_CHAN       4

// Channel word layout.
`define TCRP_VAL_HI         15
`define TCRP_VAL_LO         4
`define TCRP_FAULT_BIT      1
`define TCRP_EMPTY_HI       16'h0000
`define TCRP_EMPTY_BIT0     1'b0
`define TCRP_EMPTY_BITS23   2'b00

// Scaling span inside which status bits are carried.
`define TCRP_SCALE_MIN      16'h2710
`define TCRP_SCALE_MAX      16'hC350

// Hold-off step limit.
`define TCRP_HOLD_MAX       8'hFA

// Zero-based address bases.
`define TCRP_IREG_BASE      16'h0200
`define TCRP_HREG_BASE      16'h0600
`define TCRP_STAT_BASE      16'h0800

// Reset values and the last channel number.
`define TCRP_RST_WORD       16'h0000
`define TCRP_RST_HOLD       8'h00
`define TCRP_RST_CNT        27'h000_0000
`define TCRP_RST_CHAN       2'h0
`define TCRP_CHAN_LAST      2'h3

`endif

// ==== hdl/tcrp_chan.v ====
`timescale 1ns/100ps
`include "tcrp_consts.vh"

module tcrp_chan (
    input  wire        clk_i,        // System clock.
    input  wire        rst_i,        // Synchronous reset, active high.
    input  wire        load_i,       // One-cycle pulse: a new conversion result for this channel.
    input  wire [15:0] value_i,      // Unsigned conversion result.
    input  wire        fault_i,      // Line fault seen in this conversion.
    input  wire        lfd_en_i,     // Line fault detection enabled.
    input  wire        stat_en_i,    // Status bits carried in the low nibble.
    input  wire [7:0]  steps_i,      // Hold-off length in steps, already clamped.
    input  wire        step_tick_i,  // One-cycle pulse per hold-off step.
    output wire [15:0] word_o        // Packed channel word.
);

    reg  [15:0] word_r;
    reg  [15:0] word_nxt;
    reg         fault_r;
    reg         fault_nxt;
    reg  [7:0]  hold_r;
    reg  [7:0]  hold_nxt;
    wire        fault_now;
    wire [15:0] packed_w;

    assign fault_now = lfd_en_i & fault_i;

    // Status form keeps the 12-bit value on top; otherwise the whole result is passed.
    assign packed_w = stat_en_i ?
                      {value_i[`TCRP_VAL_HI:`TCRP_VAL_LO], `TCRP_EMPTY_BITS23,
                       fault_now, `TCRP_EMPTY_BIT0} :
                      value_i;

    always @* begin
        word_nxt  = word_r;
        fault_nxt = fault_r;
        hold_nxt  = hold_r;
        if (step_tick_i && hold_r != `TCRP_RST_HOLD) begin
            hold_nxt = hold_r - 8'h01;
        end
        if (load_i) begin
            fault_nxt = fault_now;
            if (fault_now) begin
                hold_nxt = `TCRP_RST_HOLD;
                word_nxt = packed_w;
            end else if (fault_r && steps_i != `TCRP_RST_HOLD) begin
                // Fault has just cleared: keep the faulted word while the hold-off runs.
                hold_nxt = steps_i;
            end else if (hold_r == `TCRP_RST_HOLD) begin
                word_nxt = packed_w;
            end
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            word_r  <= `TCRP_RST_WORD;
            fault_r <= 1'b0;
            hold_r  <= `TCRP_RST_HOLD;
        end else begin
            word_r  <= word_nxt;
            fault_r <= fault_nxt;
            hold_r  <= hold_nxt;
        end
    end

    assign word_o = word_r;

endmodule // tcrp_chan

// ==== hdl/tcrp_top.v ====
// Overview of operation
// - A full conversion pass over the four channels takes at most 200 ms with line fault detection off.
// - A full conversion pass over the four channels takes at most 350 ms with line fault detection on.
// - One channel word goes to the communication unit every 6.5 ms, independent of conversion.
// - Channel words go out one after the other, so a full set needs four transfer periods.
// - Each process value is an unsigned integer from 0 to 65535.
// - Each channel is one 16-bit word whose lowest four bits carry status.
// - Status bits are left out when the scaling lies outside 10000 to 50000.
// - Bit 1 flags a line fault (1 = error) and bits 0, 2 and 3 are zero.
// - Bits 4 to 15 hold the 12-bit measured value.
// - All four channel words share one layout and the block has no output data.
// - Status bit address is 2048 plus eight times the slot plus the bit number minus one.
// - Allocated process data is also read from holding registers starting at 1536.
// - Broken leads are detected per channel and detection can be switched off.
// - After a fault clears, values are withheld for 0 to 250 steps of 160 ms (external) or 240 ms (internal).
// - Temperatures are resolved with 16 bits.
`timescale 1ns/100ps
`include "tcrp_consts.vh"

module tcrp_top #(
    parameter [26:0] PASS_NOLFD_CYC = `TCRP_PASS_NOLFD_US * `TCRP_CLK_MHZ,  // Pass time, detection off.
    parameter [26:0] PASS_LFD_CYC   = `TCRP_PASS_LFD_US * `TCRP_CLK_MHZ,    // Pass time, detection on.
    parameter [26:0] XFER_CYC       = `TCRP_XFER_US * `TCRP_CLK_MHZ,        // Transfer period.
    parameter [26:0] STEP_EXT_CYC   = `TCRP_STEP_EXT_US * `TCRP_CLK_MHZ,    // Hold-off step, external junction.
    parameter [26:0] STEP_INT_CYC   = `TCRP_STEP_INT_US * `TCRP_CLK_MHZ     // Hold-off step, internal junction.
) (
    input  wire        CLOCK_I,          // System clock, 200 MHz.
    input  wire        RST_I,            // Synchronous reset, active high.
    input  wire        ADC_VALID_I,      // Front end result ready, level, from pins.
    input  wire [15:0] ADC_DATA_I,       // Front end result, stable while valid is high.
    input  wire        ADC_FAULT_I,      // Front end lead breakage seen, stable with data.
    input  wire        LFD_EN_I,         // Line fault detection on.
    input  wire        CJ_EXT_I,         // External cold junction selected.
    input  wire [7:0]  HOLD_STEPS_I,     // Hold-off length in steps.
    input  wire [15:0] SCALE_START_I,    // Scaling start point.
    input  wire [15:0] SCALE_END_I,      // Scaling end point.
    input  wire [3:0]  SLOT_I,           // Backplane slot number.
    input  wire [15:0] ALLOC_BASE_I,     // Allocated holding-register address of channel 1.
    output reg         CONV_REQ_O,       // One-cycle pulse: start a conversion.
    output reg  [1:0]  CONV_CHAN_O,      // Channel to convert.
    output reg         CONV_LFD_O,       // Run the lead check in this conversion.
    output reg         COM_STROBE_O,     // One-cycle pulse: channel word valid.
    output reg  [1:0]  COM_CHAN_O,       // Channel of the word.
    output reg  [15:0] COM_WORD_O,       // Packed channel word.
    output reg  [15:0] COM_IREG_ADDR_O,  // Slot-based input register address.
    output reg  [15:0] COM_HREG_ADDR_O,  // Allocated holding register address.
    output reg  [15:0] COM_STAT_ADDR_O   // Discrete input address of the word's fault bit.
);

    localparam [1:0] S_REQ  = 2'b01;
    localparam [1:0] S_WAIT = 2'b10;

    localparam [26:0] SLOT_NOLFD_CYC = PASS_NOLFD_CYC / `TCRP_NUM_CHAN;
    localparam [26:0] SLOT_LFD_CYC   = PASS_LFD_CYC / `TCRP_NUM_CHAN;

    // Two-stage synchronisers for every pin-level input.
    localparam integer SW = 1 + 16 + 1 + 1 + 1 + 8 + 16 + 16 + 4 + 16;

    wire [SW-1:0] pins_w;
    reg  [SW-1:0] sync1_r;
    reg  [SW-1:0] sync2_r;
    reg           valid_d_r;

    assign pins_w = {ADC_VALID_I, ADC_DATA_I, ADC_FAULT_I, LFD_EN_I, CJ_EXT_I, HOLD_STEPS_I,
                     SCALE_START_I, SCALE_END_I, SLOT_I, ALLOC_BASE_I};

    always @(posedge CLOCK_I) begin
        if (RST_I) begin
            sync1_r   <= {SW{1'b0}};
            sync2_r   <= {SW{1'b0}};
            valid_d_r <= 1'b0;
        end else begin
            sync1_r   <= pins_w;
            sync2_r   <= sync1_r;
            valid_d_r <= sync2_r[SW-1];
        end
    end

    wire        s_valid  = sync2_r[SW-1];
    wire [15:0] s_data   = sync2_r[SW-2:SW-17];
    wire        s_fault  = sync2_r[SW-18];
    wire        s_lfd    = sync2_r[SW-19];
    wire        s_cjext  = sync2_r[SW-20];
    wire [7:0]  s_steps  = sync2_r[SW-21:SW-28];
    wire [15:0] s_sstart = sync2_r[SW-29:SW-44];
    wire [15:0] s_send   = sync2_r[SW-45:SW-60];
    wire [3:0]  s_slot   = sync2_r[SW-61:SW-64];
    wire [15:0] s_alloc  = sync2_r[15:0];

    wire        result_w = s_valid & ~valid_d_r;
    wire [7:0]  steps_w  = (s_steps > `TCRP_HOLD_MAX) ? `TCRP_HOLD_MAX : s_steps;
    wire        stat_en_w = (s_sstart >= `TCRP_SCALE_MIN) && (s_sstart <= `TCRP_SCALE_MAX) &&
                            (s_send >= `TCRP_SCALE_MIN) && (s_send <= `TCRP_SCALE_MAX);

    // Conversion sequencer: each channel gets a quarter of the pass time.
    reg  [1:0]  state_r;
    reg  [1:0]  state_nxt;
    reg  [1:0]  conv_chan_r;
    reg  [1:0]  conv_chan_nxt;
    reg  [26:0] conv_cnt_r;
    reg  [26:0] conv_cnt_nxt;
    reg         conv_lfd_r;
    reg         conv_lfd_nxt;
    wire [26:0] slot_len_w = conv_lfd_r ? SLOT_LFD_CYC : SLOT_NOLFD_CYC;

    always @* begin
        state_nxt     = state_r;
        conv_chan_nxt = conv_chan_r;
        conv_cnt_nxt  = conv_cnt_r;
        conv_lfd_nxt  = conv_lfd_r;
        case (state_r)
            S_REQ: begin
                conv_cnt_nxt = `TCRP_RST_CNT;
                state_nxt    = S_WAIT;
            end
            S_WAIT: begin
                // The request state takes one cycle of the slot, so waiting ends one count early.
                if (conv_cnt_r >= slot_len_w - 27'h000_0002) begin
                    conv_cnt_nxt  = `TCRP_RST_CNT;
                    conv_chan_nxt = conv_chan_r + 2'h1;
                    // Detection mode only changes between passes.
                    if (conv_chan_r == `TCRP_CHAN_LAST) begin
                        conv_lfd_nxt = s_lfd;
                    end
                    state_nxt = S_REQ;
                end else begin
                    conv_cnt_nxt = conv_cnt_r + 27'h000_0001;
                end
            end
            default: begin
                state_nxt     = S_REQ;
                conv_chan_nxt = `TCRP_RST_CHAN;
                conv_cnt_nxt  = `TCRP_RST_CNT;
            end
        endcase
    end

    always @(posedge CLOCK_I) begin
        if (RST_I) begin
            state_r     <= S_REQ;
            conv_chan_r <= `TCRP_RST_CHAN;
            conv_cnt_r  <= `TCRP_RST_CNT;
            conv_lfd_r  <= 1'b0;
            CONV_REQ_O  <= 1'b0;
            CONV_CHAN_O <= `TCRP_RST_CHAN;
            CONV_LFD_O  <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            conv_chan_r <= conv_chan_nxt;
            conv_cnt_r  <= conv_cnt_nxt;
            conv_lfd_r  <= conv_lfd_nxt;
            CONV_REQ_O  <= (state_r == S_REQ);
            CONV_CHAN_O <= conv_chan_r;
            CONV_LFD_O  <= conv_lfd_r;
        end
    end

    // Hold-off step divider; its period follows the cold junction choice.
    reg  [26:0] step_cnt_r;
    reg         step_tick_r;
    wire [26:0] step_len_w = s_cjext ? STEP_EXT_CYC : STEP_INT_CYC;

    always @(posedge CLOCK_I) begin
        if (RST_I) begin
            step_cnt_r  <= `TCRP_RST_CNT;
            step_tick_r <= 1'b0;
        end else if (step_cnt_r >= step_len_w - 27'h000_0001) begin
            step_cnt_r  <= `TCRP_RST_CNT;
            step_tick_r <= 1'b1;
        end else begin
            step_cnt_r  <= step_cnt_r + 27'h000_0001;
            step_tick_r <= 1'b0;
        end
    end

    // One packer per channel; all share the same layout.
    wire [15:0] word_w [0:`TCRP_NUM_CHAN-1];

    genvar gi;
    generate
        for (gi = 0; gi < `TCRP_NUM_CHAN; gi = gi + 1) begin : g_chan
            tcrp_chan u_chan (
                .clk_i       (CLOCK_I),
                .rst_i       (RST_I),
                .load_i      (result_w && (conv_chan_r == gi)),
                .value_i     (s_data),
                .fault_i     (s_fault),
                .lfd_en_i    (conv_lfd_r),
                .stat_en_i   (stat_en_w),
                .steps_i     (steps_w),
                .step_tick_i (step_tick_r),
                .word_o      (word_w[gi])
            );
        end
    endgenerate

    // Transfer scheduler: one word per period, channels in turn.
    reg  [26:0] xfer_cnt_r;
    reg  [1:0]  xfer_chan_r;

    always @(posedge CLOCK_I) begin
        if (RST_I) begin
            xfer_cnt_r      <= `TCRP_RST_CNT;
            xfer_chan_r     <= `TCRP_RST_CHAN;
            COM_STROBE_O    <= 1'b0;
            COM_CHAN_O      <= `TCRP_RST_CHAN;
            COM_WORD_O      <= `TCRP_RST_WORD;
            COM_IREG_ADDR_O <= `TCRP_RST_WORD;
            COM_HREG_ADDR_O <= `TCRP_RST_WORD;
            COM_STAT_ADDR_O <= `TCRP_RST_WORD;
        end else if (xfer_cnt_r >= XFER_CYC - 27'h000_0001) begin
            xfer_cnt_r      <= `TCRP_RST_CNT;
            xfer_chan_r     <= xfer_chan_r + 2'h1;
            COM_STROBE_O    <= 1'b1;
            COM_CHAN_O      <= xfer_chan_r;
            COM_WORD_O      <= word_w[xfer_chan_r];
            COM_IREG_ADDR_O <= `TCRP_IREG_BASE + {11'h000, s_slot, 1'b0}
                               + {14'h0000, xfer_chan_r};
            COM_HREG_ADDR_O <= `TCRP_HREG_BASE + s_alloc
                               + {14'h0000, xfer_chan_r};
            COM_STAT_ADDR_O <= `TCRP_STAT_BASE + {9'h000, s_slot, 3'h0}
                               + {14'h0000, xfer_chan_r};
        end else begin
            xfer_cnt_r      <= xfer_cnt_r + 27'h000_0001;
            COM_STROBE_O    <= 1'b0;
        end
    end

endmodule // tcrp_top

// ==== tb/tcrp_top_asserts.sv ====
`timescale 1ns/100ps
`include "tcrp_consts.vh"
module tcrp_chk #(
    parameter [26:0] PASS_NOLFD_CYC = 27'h000_0190,
    parameter [26:0] PASS_LFD_CYC   = 27'h000_02BC,
    parameter [26:0] XFER_CYC       = 27'h000_0041
) (
    input wire logic        CLOCK_I,          // Clock.
    input wire logic        RST_I,            // Reset.
    input wire logic [3:0]  SLOT_I,           // Slot.
    input wire logic [15:0] ALLOC_BASE_I,     // Allocated base.
    input wire logic        CONV_REQ_O,       // Conversion request.
    input wire logic [1:0]  CONV_CHAN_O,      // Conversion channel.
    input wire logic        CONV_LFD_O,       // Lead check on.
    input wire logic        COM_STROBE_O,     // Word strobe.
    input wire logic [1:0]  COM_CHAN_O,       // Word channel.
    input wire logic [15:0] COM_WORD_O,       // Word.
    input wire logic [15:0] COM_IREG_ADDR_O,  // Input register address.
    input wire logic [15:0] COM_HREG_ADDR_O,  // Holding register address.
    input wire logic [15:0] COM_STAT_ADDR_O   // Status bit address.
);
    localparam int XP = XFER_CYC;
    localparam int PN = PASS_NOLFD_CYC;
    localparam int PL = PASS_LFD_CYC;
    reg [26:0] gap_r;
    reg [26:0] pc_r;
    reg        lfd_r;
    reg [2:0]  seen_r;
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);
    // Cycle counters since the last word strobe and since the last channel 0 request.
    always @(posedge CLOCK_I) begin
        if (RST_I) begin
            gap_r  <= 27'h000_0000;
            pc_r   <= 27'h000_0000;
            lfd_r  <= 1'b0;
            seen_r <= 3'h0;
        end else begin
            gap_r  <= COM_STROBE_O ? 27'h000_0000 : gap_r + 27'h000_0001;
            pc_r   <= (CONV_REQ_O && CONV_CHAN_O == 2'h0) ? 27'h000_0001 : pc_r + 27'h000_0001;
            lfd_r  <= (CONV_REQ_O && CONV_CHAN_O == 2'h0) ? CONV_LFD_O : lfd_r;
            seen_r <= seen_r | {CONV_REQ_O && CONV_CHAN_O == 2'h0, CONV_REQ_O, COM_STROBE_O};
        end
    end
    strobe_pulse_a: assert property (COM_STROBE_O |=> !COM_STROBE_O [*8])
        else $error("strobe longer than one cycle");
    strobe_period_a: assert property (COM_STROBE_O |-> ##XP COM_STROBE_O)
        else $error("strobe missing after one period");
    strobe_gap_a: assert property (COM_STROBE_O && seen_r[0] |-> gap_r == XP - 1)
        else $error("strobe spacing wrong");
    word_order_a: assert property (COM_STROBE_O && seen_r[0] |-> COM_CHAN_O == 2'($past(COM_CHAN_O) + 2'h1))
        else $error("word channel out of order");
    word_hold_a: assert property (!COM_STROBE_O |-> $stable(COM_WORD_O) && $stable(COM_CHAN_O))
        else $error("word changed without strobe");
    ireg_addr_a: assert property (COM_STROBE_O |->
        COM_IREG_ADDR_O == `TCRP_IREG_BASE + {SLOT_I, 1'b0} + COM_CHAN_O)
        else $error("input register address wrong");
    hreg_addr_a: assert property (COM_STROBE_O |->
        COM_HREG_ADDR_O == `TCRP_HREG_BASE + ALLOC_BASE_I + COM_CHAN_O)
        else $error("holding register address wrong");
    stat_addr_a: assert property (COM_STROBE_O |->
        COM_STAT_ADDR_O == `TCRP_STAT_BASE + {SLOT_I, 3'b000} + COM_CHAN_O)
        else $error("status bit address wrong");
    conv_order_a: assert property (CONV_REQ_O && seen_r[1] |-> CONV_CHAN_O == 2'($past(CONV_CHAN_O) + 2'h1))
        else $error("conversion channel out of order");
    pass_time_a: assert property (CONV_REQ_O && CONV_CHAN_O == 2'h0 && seen_r[2] |->
        pc_r <= (lfd_r ? PL : PN))
        else $error("conversion pass too long");
    cover property (COM_STROBE_O && COM_CHAN_O == 2'h3);
    cover property (CONV_REQ_O && CONV_LFD_O);
    cover property (COM_STROBE_O && COM_WORD_O[1]);
endmodule // tcrp_chk

// ==== tb/tcrp_fe_model.sv ====
`timescale 1ns/100ps
module tcrp_fe_model (
    input  wire logic        clk_i,    // Clock.
    input  wire logic        req_i,    // Conversion request.
    input  wire logic [1:0]  chan_i,   // Channel to convert.
    input  wire logic [63:0] vals_i,   // Values of all channels, channel 0 lowest.
    input  wire logic [3:0]  flts_i,   // Lead breakage of all channels.
    output logic             valid_o,  // Result ready.
    output logic [15:0]      data_o,   // Result.
    output logic             fault_o   // Lead breakage in result.
);
    integer     cnt = 99;
    logic [1:0] ch  = 2'h0;
    initial begin
        valid_o = 1'b0;
        data_o  = 16'h5A5A;
        fault_o = 1'b0;
    end
    // Data settles six cycles before valid and is inverted once its hold time has run out.
    always @(posedge clk_i) begin
        cnt <= req_i ? 0 : (cnt < 99 ? cnt + 1 : cnt);
        if (req_i) ch <= chan_i;
        if (cnt == 6) begin
            data_o  <= vals_i[ch*16 +: 16];
            fault_o <= flts_i[ch];
        end
        if (cnt == 12) valid_o <= 1'b1;
        if (cnt == 30) valid_o <= 1'b0;
        if (cnt == 36) begin
            data_o  <= ~data_o;
            fault_o <= ~fault_o;
        end
    end
endmodule // tcrp_fe_model

// ==== tb/tb_thermocouple_readout_packer.sv ====
`timescale 1ns/100ps
`include "tcrp_consts.vh"
module tb_thermocouple_readout_packer;
    logic        clk = 1'b0, rst = 1'b1, lfd_en = 1'b0, cj_ext = 1'b1, held = 1'b0;
    logic [7:0]  hold_steps = 8'h00;
    logic [15:0] scale_start = 16'h2710, scale_end = 16'hC350, alloc_base = 16'h0000, held_word = 16'h0000;
    logic [3:0]  slot = 4'h0, flts = 4'h0;
    logic [63:0] vals = 64'h0000_0000_0000_0000;
    wire         adc_valid, adc_fault, conv_req, conv_lfd, com_strobe;
    wire [1:0]   conv_chan, com_chan;
    wire [15:0]  adc_data, com_word, ireg, hreg, stat;
    integer      num_errors = 0, compares = 0, seed = 59, cycles = 0;

    tcrp_fe_model fe_u (.clk_i(clk), .req_i(conv_req), .chan_i(conv_chan), .vals_i(vals), .flts_i(flts),
        .valid_o(adc_valid), .data_o(adc_data), .fault_o(adc_fault));
    tcrp_top #(.PASS_NOLFD_CYC(27'h000_0190), .PASS_LFD_CYC(27'h000_02BC), .XFER_CYC(27'h000_0041),
        .STEP_EXT_CYC(27'h000_0020), .STEP_INT_CYC(27'h000_0030)) dut_u (
        .CLOCK_I(clk), .RST_I(rst), .ADC_VALID_I(adc_valid), .ADC_DATA_I(adc_data), .ADC_FAULT_I(adc_fault),
        .LFD_EN_I(lfd_en), .CJ_EXT_I(cj_ext), .HOLD_STEPS_I(hold_steps), .SCALE_START_I(scale_start),
        .SCALE_END_I(scale_end), .SLOT_I(slot), .ALLOC_BASE_I(alloc_base), .CONV_REQ_O(conv_req),
        .CONV_CHAN_O(conv_chan), .CONV_LFD_O(conv_lfd), .COM_STROBE_O(com_strobe), .COM_CHAN_O(com_chan),
        .COM_WORD_O(com_word), .COM_IREG_ADDR_O(ireg), .COM_HREG_ADDR_O(hreg), .COM_STAT_ADDR_O(stat));

    initial forever #2.5 clk = ~clk;

    // Expected channel word from the configuration the bench applied.
    function [15:0] exp_word(input [1:0] c);
        logic st;
        st = scale_start >= `TCRP_SCALE_MIN && scale_start <= `TCRP_SCALE_MAX &&
             scale_end >= `TCRP_SCALE_MIN && scale_end <= `TCRP_SCALE_MAX;
        if (held && c == 2'h2) exp_word = held_word;
        else if (st) exp_word = {vals[c*16+4 +: 12], 2'b00, flts[c] & lfd_en, 1'b0};
        else exp_word = vals[c*16 +: 16];
    endfunction

    task wrap_up;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task chk(input [15:0] seen, input [15:0] expv);
        compares = compares + 1;
        if (seen !== expv) begin
            num_errors = num_errors + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask

    task next_strobe;
        integer k;
        k = 0;
        @(negedge clk);
        while (com_strobe !== 1'b1 && k < 200) begin
            @(negedge clk);
            k = k + 1;
        end
        if (k >= 200) num_errors = num_errors + 1;
    endtask

    task run_phase(input integer n, input integer settle);
        repeat (settle) next_strobe;
        repeat (8) begin
            next_strobe;
            chk(com_word, exp_word(com_chan));
            chk({15'h0000, conv_lfd}, {15'h0000, lfd_en});
        end
        $display("test %0d done", n);
    endtask

    task set_cfg(input l, input [15:0] ss, input [15:0] se, input [63:0] v);
        @(posedge clk);
        lfd_en      <= l;
        scale_start <= ss;
        scale_end   <= se;
        vals        <= v;
        flts        <= $random(seed);
        slot        <= $random(seed);
        alloc_base  <= $random(seed);
        cj_ext      <= $random(seed);
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 45000) begin
            num_errors = num_errors + 1;
            wrap_up;
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        set_cfg(1'b0, 16'h2710, 16'hC350, {$random(seed), $random(seed)});
        run_phase(1, 30);
        set_cfg(1'b1, 16'h2710, 16'hC350, {$random(seed), $random(seed)});
        run_phase(2, 30);
        set_cfg(1'b1, 16'h270F, 16'hC350, {$random(seed), $random(seed)});
        run_phase(3, 30);
        set_cfg(1'b1, 16'h4E20, 16'hC351, {$random(seed), $random(seed)});
        run_phase(4, 30);
        set_cfg(1'b0, 16'h4E20, 16'h9C40, 64'hFFFF_0000_000F_FFF0);
        run_phase(5, 30);
        set_cfg(1'b1, 16'h2710, 16'hC350, {$random(seed), $random(seed)});
        @(posedge clk);
        flts       <= 4'h4;
        cj_ext     <= 1'b0;
        hold_steps <= 8'hFF;
        run_phase(6, 30);
        held_word = exp_word(2'h2);
        held = 1'b1;
        @(posedge clk);
        flts <= 4'h0;
        run_phase(7, 30);
        run_phase(8, 110);
        held = 1'b0;
        run_phase(9, 60);
        wrap_up;
    end
endmodule // tb_thermocouple_readout_packer

bind tcrp_top tcrp_chk #(.PASS_NOLFD_CYC(PASS_NOLFD_CYC), .PASS_LFD_CYC(PASS_LFD_CYC), .XFER_CYC(XFER_CYC)) chk_u (
    .CLOCK_I(CLOCK_I), .RST_I(RST_I), .SLOT_I(SLOT_I), .ALLOC_BASE_I(ALLOC_BASE_I), .CONV_REQ_O(CONV_REQ_O),
    .CONV_CHAN_O(CONV_CHAN_O), .CONV_LFD_O(CONV_LFD_O), .COM_STROBE_O(COM_STROBE_O), .COM_CHAN_O(COM_CHAN_O),
    .COM_WORD_O(COM_WORD_O), .COM_IREG_ADDR_O(COM_IREG_ADDR_O), .COM_HREG_ADDR_O(COM_HREG_ADDR_O),
    .COM_STAT_ADDR_O(COM_STAT_ADDR_O));
